// [common/hpd_map.svh]
// Constants for the host port decode block: offsets, codes, times.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef HPD_MAP_SVH
`define HPD_MAP_SVH

`define HPD_CLK_KHZ 32'd100000
`define HPD_PORT_FIRST 1'b0
`define HPD_PORT_SECOND 1'b1
`define HPD_BASE_RESET 16'h0000
`define HPD_IRQ_DEFAULT 3'h5
`define HPD_CTRL_SOFT_RST 0
`define HPD_CTRL_IRQ_CLR 1
`define HPD_STAT_READY 7
`define HPD_STAT_IRQ 6
`define HPD_STAT_HALT 5
`define HPD_FAULT_CFG_ADDR 8'ha0
`define HPD_FAULT_MEM_LOW 8'hb1
`define HPD_FAULT_MEM_HIGH 8'hb2
`define HPD_FAULT_PARITY 8'hc8
`define HPD_FAULT_NMI 8'hc9
`define HPD_FAULT_HOST_IRQ 8'hca
`define HPD_MEM_LOW_LIMIT 19'h20000
`define HPD_TIMEOUT_MS 32'd30
`define HPD_SELFTEST_MS 32'd3000
`define HPD_BLINK_MS 32'd500
`define HPD_LONG_MS 32'd750
`define HPD_SHORT_MS 32'd250
`define HPD_GAP_MS 32'd250
`define HPD_PAUSE_MS 32'd2000
`define HPD_NMI_WAIT_CYC 32'd16

`endif

// [common/hpd_pkg.sv]
// Types shared by the host port decode block and its lamp driver.
// Assumes nothing beyond a SystemVerilog compiler.
package hpd_pkg;
    typedef enum logic [3:0] {
        HPD_ST_SELFTEST = 4'b0001,
        HPD_ST_READY = 4'b0010,
        HPD_ST_RUN = 4'b0100,
        HPD_ST_HALT = 4'b1000
    } hpd_state_e;

    typedef enum logic [3:0] {
        HPD_LAMP_OFF = 4'b0001,
        HPD_LAMP_ON = 4'b0010,
        HPD_LAMP_BLINK = 4'b0100,
        HPD_LAMP_CODE = 4'b1000
    } hpd_lamp_mode_e;

    typedef enum logic [2:0] {
        HPD_PH_MARK = 3'b001,
        HPD_PH_GAP = 3'b010,
        HPD_PH_PAUSE = 3'b100
    } hpd_phase_e;
endpackage

// [common/hpd_lamp_if.sv]
// Carrier between the port logic and the status lamp driver.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
interface hpd_lamp_if;
    import hpd_pkg::*;
    hpd_lamp_mode_e mode;
    logic [7:0] code;
    modport ctrl (output mode, output code);
    modport lamp (input mode, input code);
endinterface

// [verilog/hpd_lamp.sv]
// Status lamp driver: steady, even blink, or serial fault code.
// Assumes a synchronous active-low reset from the top.
`timescale 1ns/1ps
`include "hpd_map.svh"
module hpd_lamp
    import hpd_pkg::*;
#(
    parameter logic [31:0] BLINK_CYC = 32'd50000000,
    parameter logic [31:0] LONG_CYC = 32'd75000000,
    parameter logic [31:0] SHORT_CYC = 32'd25000000,
    parameter logic [31:0] GAP_CYC = 32'd25000000,
    parameter logic [31:0] PAUSE_CYC = 32'd200000000
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    hpd_lamp_if.lamp ctl,
    output logic status_lamp_o
);
    hpd_phase_e ph_q, ph_d;
    logic [31:0] cnt_q, cnt_d;
    logic [2:0] bit_q, bit_d;
    logic lamp_q, lamp_d;
    logic [31:0] mark_len;

    always_comb begin
        mark_len = ctl.code[bit_q] ? LONG_CYC : SHORT_CYC;
        ph_d = ph_q;
        bit_d = bit_q;
        cnt_d = cnt_q + 32'd1;
        lamp_d = 1'b0;
        unique case (ctl.mode)
            HPD_LAMP_OFF: begin
                cnt_d = '0;
            end
            HPD_LAMP_ON: begin
                lamp_d = 1'b1;
                cnt_d = '0;
            end
            HPD_LAMP_BLINK: begin
                // Even duty: same time lit and dark
                if (cnt_q >= (BLINK_CYC << 1) - 32'd1) begin
                    cnt_d = '0;
                end
                lamp_d = (cnt_q < BLINK_CYC);
            end
            HPD_LAMP_CODE: begin
                // MSB first, long for one, short for zero, pause then repeat
                unique case (ph_q)
                    HPD_PH_MARK: begin
                        lamp_d = 1'b1;
                        if (cnt_q >= mark_len - 32'd1) begin
                            cnt_d = '0;
                            ph_d = HPD_PH_GAP;
                        end
                    end
                    HPD_PH_GAP: begin
                        if (cnt_q >= GAP_CYC - 32'd1) begin
                            cnt_d = '0;
                            bit_d = bit_q - 3'd1;
                            ph_d = (bit_q == 3'd0) ? HPD_PH_PAUSE : HPD_PH_MARK;
                        end
                    end
                    HPD_PH_PAUSE: begin
                        if (cnt_q >= PAUSE_CYC - 32'd1) begin
                            cnt_d = '0;
                            bit_d = 3'd7;
                            ph_d = HPD_PH_MARK;
                        end
                    end
                    default: begin
                        ph_d = HPD_PH_PAUSE;
                        cnt_d = '0;
                    end
                endcase
            end
            default: begin
                cnt_d = '0;
            end
        endcase
        if (ctl.mode != HPD_LAMP_CODE) begin
            // Code always restarts from its top bit after a pause
            ph_d = HPD_PH_PAUSE;
            bit_d = 3'd7;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ph_q <= HPD_PH_PAUSE;
            cnt_q <= '0;
            bit_q <= 3'd7;
            lamp_q <= 1'b1;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            lamp_q <= lamp_d;
        end
    end

    assign status_lamp_o = lamp_q;
endmodule

// [verilog/hpd_top.sv]
// Host port logic: two-port I/O decode, bus interrupt, bus timeout, fault codes.
// Assumes host strobes synchronous to clock_i and held until acknowledged.
`timescale 1ns/1ps
`include "hpd_map.svh"
// Function
// - Device occupies two adjacent byte ports, first and second.
// - With no straps fitted, ports decode at addresses zero and one.
// - Base address strap-selectable over the whole 16-bit I/O range.
// - Decode compares either eight or sixteen address bits, strap-selected.
// - One strap-selected bus interrupt level out of eight.
// - Default interrupt selection drives level five.
// - Unacknowledged bus transfer aborts after 30 ms; enable strap-selectable.
// - Invalid configuration address halts with fault code A0.
// - Memory failure below 128K gives B1, above gives B2.
// - Missing NMI after bus timeout gives fault code C9.
// - Failed host interrupt path test gives fault code CA.
// - Failed parity checking logic gives fault code C8.
// - Fault code shown MSB first, long one, short zero, repeated.
// - Lamp lit in self-test, even blink until initialized, then off.
// - After reset, self-test ends within three seconds, then ready.
module hpd_top
    import hpd_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_CYC = `HPD_TIMEOUT_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] SELFTEST_CYC = `HPD_SELFTEST_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] BLINK_CYC = `HPD_BLINK_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] LONG_CYC = `HPD_LONG_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] SHORT_CYC = `HPD_SHORT_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] GAP_CYC = `HPD_GAP_MS * `HPD_CLK_KHZ,
    parameter logic [31:0] PAUSE_CYC = `HPD_PAUSE_MS * `HPD_CLK_KHZ
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_ack_o,
    input wire logic [15:1] strap_base_i,
    input wire logic strap_wide_i,
    input wire logic [2:0] strap_irq_i,
    input wire logic strap_timeout_en_i,
    output logic [7:0] bus_interrupt_levels_o,
    input wire logic [7:0] fw_status_i,
    output logic [7:0] fw_cmd_o,
    output logic fw_cmd_valid_o,
    input wire logic fw_irq_req_i,
    input wire logic selftest_done_i,
    input wire logic init_done_i,
    input wire logic mst_req_i,
    input wire logic mst_ack_i,
    output logic mst_abort_o,
    output logic nmi_o,
    input wire logic nmi_taken_i,
    input wire logic cfg_bad_addr_i,
    input wire logic mem_fail_i,
    input wire logic [18:0] mem_fail_addr_i,
    input wire logic parity_fail_i,
    input wire logic irq_test_fail_i,
    output logic ready_o,
    output logic halted_o,
    output logic status_lamp_o
);
    // Address match; narrow mode ignores the upper byte
    function automatic logic port_hit(input logic [15:0] a, input logic [15:1] b,
                                      input logic wide);
        port_hit = wide ? (a[15:1] == b) : (a[7:1] == b[7:1]);
    endfunction

    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Straps caught once after reset release, not under the async reset
    logic cap_q, cap_d, wide_q, wide_d, tmo_en_q, tmo_en_d;
    logic [15:1] base_q, base_d;
    logic [2:0] lvl_q, lvl_d;
    always_comb begin
        cap_d = 1'b1;
        base_d = base_q;
        wide_d = wide_q;
        lvl_d = lvl_q;
        tmo_en_d = tmo_en_q;
        if (!cap_q) begin
            base_d = strap_base_i;
            wide_d = strap_wide_i;
            lvl_d = strap_irq_i ^ `HPD_IRQ_DEFAULT; // Unfitted reads 0 -> level 5
            tmo_en_d = strap_timeout_en_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n) begin
            cap_q <= 1'b0;
            base_q <= 15'(`HPD_BASE_RESET >> 1);
            wide_q <= 1'b1;
            lvl_q <= `HPD_IRQ_DEFAULT;
            tmo_en_q <= 1'b0;
        end else begin
            cap_q <= cap_d;
            base_q <= base_d;
            wide_q <= wide_d;
            lvl_q <= lvl_d;
            tmo_en_q <= tmo_en_d;
        end
    end

    // Host port access
    hpd_state_e st_q, st_d;
    logic hit, take_rd, take_wr;
    logic ack_q, ack_d, cmdv_q, cmdv_d, irq_q, irq_d, soft_rst;
    logic [7:0] rdata_q, rdata_d, cmd_q, cmd_d, code_q, code_d;
    assign hit = cap_q && port_hit(io_addr_i, base_q, wide_q);
    assign take_rd = hit && io_rd_i && !ack_q;
    assign take_wr = hit && io_wr_i && !ack_q;
    assign soft_rst = take_wr && (io_addr_i[0] == `HPD_PORT_SECOND)
                      && io_wdata_i[`HPD_CTRL_SOFT_RST];
    always_comb begin
        ack_d = take_rd || take_wr;
        rdata_d = rdata_q;
        cmd_d = cmd_q;
        cmdv_d = 1'b0;
        irq_d = irq_q;
        // Lowest address bit picks the port
        if (take_rd && io_addr_i[0] == `HPD_PORT_FIRST) begin
            rdata_d = fw_status_i;
            irq_d = 1'b0;
        end else if (take_rd) begin
            rdata_d = (st_q == HPD_ST_HALT) ? code_q : 8'h00;
            rdata_d[`HPD_STAT_READY] = (st_q == HPD_ST_HALT) ? code_q[7] : ready_o;
            if (st_q != HPD_ST_HALT) begin
                rdata_d[`HPD_STAT_IRQ] = irq_q;
                rdata_d[`HPD_STAT_HALT] = 1'b0;
            end
        end
        if (take_wr && io_addr_i[0] == `HPD_PORT_FIRST) begin
            cmd_d = io_wdata_i;
            cmdv_d = 1'b1;
        end else if (take_wr && io_wdata_i[`HPD_CTRL_IRQ_CLR]) begin
            irq_d = 1'b0;
        end
        // A new request beats a same-cycle clear
        if (fw_irq_req_i) begin
            irq_d = 1'b1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            cmd_q <= 8'h00;
            cmdv_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            cmd_q <= cmd_d;
            cmdv_q <= cmdv_d;
            irq_q <= irq_d;
        end
    end

    // One-hot drive on the strapped level only
    logic [7:0] lvl_vec;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_lvl
            assign lvl_vec[gi] = irq_q && (lvl_q == 3'(gi));
        end
    endgenerate

    // Bus timeout and NMI watch
    logic [31:0] tmo_q, tmo_d;
    logic [4:0] nmiw_q, nmiw_d;
    logic abort_q, abort_d, nmi_q, nmi_d, nmi_lost;
    always_comb begin
        tmo_d = '0;
        abort_d = 1'b0;
        nmi_d = 1'b0;
        nmiw_d = (nmiw_q != 5'd0 && !nmi_taken_i) ? nmiw_q - 5'd1 : 5'd0;
        nmi_lost = (nmiw_q == 5'd1) && !nmi_taken_i;
        if (mst_req_i && !mst_ack_i && tmo_en_q && !abort_q) begin
            tmo_d = tmo_q + 32'd1;
            if (tmo_q >= TIMEOUT_CYC - 32'd1) begin
                tmo_d = '0;
                abort_d = 1'b1;
                nmi_d = 1'b1;
                nmiw_d = 5'(`HPD_NMI_WAIT_CYC);
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n) begin
            tmo_q <= '0;
            nmiw_q <= 5'd0;
            abort_q <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            tmo_q <= tmo_d;
            nmiw_q <= nmiw_d;
            abort_q <= abort_d;
            nmi_q <= nmi_d;
        end
    end

    // Board state and fault capture; first fault wins and halts
    logic [31:0] st_cnt_q, st_cnt_d;
    logic [7:0] new_code;
    logic fault;
    always_comb begin
        fault = 1'b1;
        new_code = 8'h00;
        if (cfg_bad_addr_i) begin
            new_code = `HPD_FAULT_CFG_ADDR;
        end else if (mem_fail_i) begin
            new_code = (mem_fail_addr_i < `HPD_MEM_LOW_LIMIT) ?
                       `HPD_FAULT_MEM_LOW : `HPD_FAULT_MEM_HIGH;
        end else if (parity_fail_i) begin
            new_code = `HPD_FAULT_PARITY;
        end else if (nmi_lost) begin
            new_code = `HPD_FAULT_NMI;
        end else if (irq_test_fail_i) begin
            new_code = `HPD_FAULT_HOST_IRQ;
        end else begin
            fault = 1'b0;
        end
        st_d = st_q;
        code_d = code_q;
        st_cnt_d = '0;
        unique case (st_q)
            HPD_ST_SELFTEST: begin
                st_cnt_d = st_cnt_q + 32'd1;
                // Three-second budget also closes self
                if (selftest_done_i || st_cnt_q >= SELFTEST_CYC - 32'd1) begin
                    st_d = HPD_ST_READY;
                end
            end
            HPD_ST_READY: begin
                if (init_done_i) begin
                    st_d = HPD_ST_RUN;
                end
            end
            HPD_ST_RUN: begin
            end
            HPD_ST_HALT: begin
            end
            default: begin
                st_d = HPD_ST_HALT;
            end
        endcase
        if (fault && st_q != HPD_ST_HALT) begin
            st_d = HPD_ST_HALT;
            code_d = new_code;
        end
        if (soft_rst) begin
            st_d = HPD_ST_SELFTEST;
            code_d = 8'h00;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n) begin
            st_q <= HPD_ST_SELFTEST;
            st_cnt_q <= '0;
            code_q <= 8'h00;
        end else begin
            st_q <= st_d;
            st_cnt_q <= st_cnt_d;
            code_q <= code_d;
        end
    end

    hpd_lamp_if lamp_bus ();
    always_comb begin
        unique case (st_q)
            HPD_ST_SELFTEST: lamp_bus.mode = HPD_LAMP_ON;
            HPD_ST_READY: lamp_bus.mode = HPD_LAMP_BLINK;
            HPD_ST_RUN: lamp_bus.mode = HPD_LAMP_OFF;
            default: lamp_bus.mode = HPD_LAMP_CODE;
        endcase
        lamp_bus.code = code_q;
    end

    hpd_lamp #(
        .BLINK_CYC(BLINK_CYC),
        .LONG_CYC(LONG_CYC),
        .SHORT_CYC(SHORT_CYC),
        .GAP_CYC(GAP_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_lamp (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .ctl(lamp_bus.lamp),
        .status_lamp_o(status_lamp_o)
    );

    assign io_ack_o = ack_q;
    assign io_rdata_o = rdata_q;
    assign fw_cmd_o = cmd_q;
    assign fw_cmd_valid_o = cmdv_q;
    assign bus_interrupt_levels_o = lvl_vec;
    assign mst_abort_o = abort_q;
    assign nmi_o = nmi_q;
    assign ready_o = (st_q == HPD_ST_READY) || (st_q == HPD_ST_RUN);
    assign halted_o = (st_q == HPD_ST_HALT);
endmodule

// [tb/hpd_top_sva.sv]
// Checker on the pins of hpd_top: host acks, interrupt level, bus timeout, halt.
// Assumes straps stay put between resets.
`timescale 1ns/1ps
module hpd_top_sva #(
    parameter logic [31:0] SELFTEST_CYC = 32'd500
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic io_ack_o,
    input wire logic fw_cmd_valid_o,
    input wire logic [2:0] strap_irq_i,
    input wire logic [7:0] bus_interrupt_levels_o,
    input wire logic strap_timeout_en_i,
    input wire logic mst_req_i,
    input wire logic mst_ack_i,
    input wire logic mst_abort_o,
    input wire logic nmi_o,
    input wire logic ready_o,
    input wire logic halted_o
);
    logic [31:0] wait_q;
    logic [31:0] wait_d;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    // Cycles spent neither ready nor halted
    always_comb begin
        wait_d = (ready_o || halted_o) ? 32'h0 : wait_q + 32'h1;
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 32'h0;
        end else begin
            wait_q <= wait_d;
        end
    end
    AST_ACK_ONE: assert property (io_ack_o |=> !io_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (io_ack_o |-> $past(io_rd_i || io_wr_i))
        else $error("ack without strobe");
    AST_CMD_WR: assert property (fw_cmd_valid_o |-> io_ack_o && $past(io_wr_i))
        else $error("command pulse without write");
    AST_IRQ_SEL: assert property (bus_interrupt_levels_o != 8'h00 |->
        bus_interrupt_levels_o == (8'h01 << (strap_irq_i ^ 3'h5)))
        else $error("wrong interrupt level");
    AST_ABORT_NMI: assert property (mst_abort_o |-> nmi_o ##1 !mst_abort_o)
        else $error("abort without nmi");
    AST_ABORT_CAUSE: assert property (mst_abort_o |-> strap_timeout_en_i
        && $past(mst_req_i && !mst_ack_i) && $past(mst_req_i && !mst_ack_i, 2))
        else $error("abort without stalled cycle");
    AST_HALT_STAYS: assert property (halted_o && !io_wr_i |=> halted_o)
        else $error("halt left without write");
    AST_SELFTEST_BOUND: assert property (wait_q <= SELFTEST_CYC + 32'd8)
        else $error("self-test too long");
endmodule

bind hpd_top hpd_top_sva #(.SELFTEST_CYC(SELFTEST_CYC)) u_sva (.clock_i, .arst_n_i,
    .io_rd_i, .io_wr_i, .io_ack_o, .fw_cmd_valid_o, .strap_irq_i, .bus_interrupt_levels_o,
    .strap_timeout_en_i, .mst_req_i, .mst_ack_i, .mst_abort_o, .nmi_o, .ready_o, .halted_o);

// [tb/hpd_host.sv]
// Host processor model: byte I/O cycles toward the port logic.
// Assumes a one-cycle registered ack; caller keeps one cycle at a time.
`timescale 1ns/1ps
module hpd_host (
    input wire logic clock_i,
    input wire logic io_ack_i,
    input wire logic [7:0] io_rdata_i,
    output logic [15:0] io_addr_o,
    output logic io_rd_o,
    output logic io_wr_o,
    output logic [7:0] io_wdata_o
);
    initial begin
        io_addr_o = 16'h0000;
        io_rd_o = 1'b0;
        io_wr_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // Strobe held through the edge that sees the ack
    task automatic cycle(input logic wr, input logic [15:0] a, input logic [7:0] x,
                         output logic hit, output logic [7:0] rdata);
        @(negedge clock_i);
        io_addr_o = a;
        io_wdata_o = x;
        io_rd_o = !wr;
        io_wr_o = wr;
        hit = 1'b0;
        rdata = 8'h00;
        for (int i = 0; i < 8 && !hit; i++) begin
            @(negedge clock_i);
            if (io_ack_i === 1'b1) begin
                hit = 1'b1;
                rdata = io_rdata_i;
            end
        end
        if (hit) @(negedge clock_i);
        io_rd_o = 1'b0;
        io_wr_o = 1'b0;
        // Released lines must not keep the old value
        io_addr_o = ~a;
        io_wdata_o = ~x;
    endtask
endmodule

// [tb/hpd_top_tb.sv]
// Self-checking bench for hpd_top, host model on the port bus.
// Assumes the shortened lamp and timeout counts given at the instance.
`timescale 1ns/1ps
module hpd_top_tb;
    import hpd_pkg::*;
    logic clock_i = 1'b0, arst_n_i = 1'b0, strap_wide_i = 1'b1, strap_timeout_en_i = 1'b1;
    logic [15:1] strap_base_i = 15'h0000;
    logic [2:0] strap_irq_i = 3'h0;
    logic [7:0] fw_status_i = 8'h00;
    logic fw_irq_req_i = 1'b0, init_done_i = 1'b0, mst_req_i = 1'b0, mst_ack_i = 1'b0;
    logic nmi_taken_i = 1'b0, cfg_bad_addr_i = 1'b0, mem_fail_i = 1'b0;
    logic parity_fail_i = 1'b0, irq_test_fail_i = 1'b0, selftest_done_i = 1'b0;
    logic [18:0] mem_fail_addr_i = 19'h00000;
    logic [15:0] io_addr_i, b;
    logic io_rd_i, io_wr_i, io_ack_o, fw_cmd_valid_o, mst_abort_o, nmi_o;
    logic ready_o, halted_o, status_lamp_o, hit;
    logic [7:0] io_wdata_i, io_rdata_o, fw_cmd_o, bus_interrupt_levels_o, r;
    logic [2:0] q;
    logic [8:0] e;
    logic [8:0] rd_q[$];
    logic [7:0] cmd_q[$];
    logic [7:0] codes[6] = '{8'ha0, 8'hb1, 8'hb2, 8'hc8, 8'hca, 8'hc9};
    int num_errors = 0, compares = 0, seed = 53632, n;
    localparam logic [31:0] TMO_CYC = 32'd200, ST_CYC = 32'd500, BL_CYC = 32'd10;
    localparam logic [31:0] LG_CYC = 32'd6, SH_CYC = 32'd2, PS_CYC = 32'd20;
    always #5 clock_i = ~clock_i;
    hpd_top #(.TIMEOUT_CYC(TMO_CYC), .SELFTEST_CYC(ST_CYC), .BLINK_CYC(BL_CYC),
        .LONG_CYC(LG_CYC), .SHORT_CYC(SH_CYC), .GAP_CYC(SH_CYC), .PAUSE_CYC(PS_CYC)) dut (
        .clock_i, .arst_n_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o,
        .io_ack_o, .strap_base_i, .strap_wide_i, .strap_irq_i, .strap_timeout_en_i,
        .bus_interrupt_levels_o, .fw_status_i, .fw_cmd_o, .fw_cmd_valid_o, .fw_irq_req_i,
        .selftest_done_i, .init_done_i, .mst_req_i, .mst_ack_i, .mst_abort_o, .nmi_o,
        .nmi_taken_i, .cfg_bad_addr_i, .mem_fail_i, .mem_fail_addr_i, .parity_fail_i,
        .irq_test_fail_i, .ready_o, .halted_o, .status_lamp_o);
    hpd_host host (.clock_i, .io_ack_i(io_ack_o), .io_rdata_i(io_rdata_o),
        .io_addr_o(io_addr_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i), .io_wdata_o(io_wdata_i));
    task automatic check(input string name, input logic [7:0] x, input logic [7:0] got);
        compares++;
        if (got !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, x, got);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Results are registered at the taking edge and checked on the next falling edge
    always @(negedge clock_i) begin
        if (io_ack_o === 1'b1) begin
            if (rd_q.size() == 0) check("io_ack_o", 8'h00, 8'h01);
            else begin
                e = rd_q.pop_front();
                if (e[8]) check("io_rdata_o", e[7:0], io_rdata_o);
            end
        end
        if (fw_cmd_valid_o === 1'b1) check("fw_cmd_o", cmd_q.pop_front(), fw_cmd_o);
    end
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        rd_q.push_back({1'b1, x});
        host.cycle(1'b0, a, 8'h00, hit, r);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] x);
        rd_q.push_back({1'b0, x});
        if (!a[0]) cmd_q.push_back(x);
        host.cycle(1'b1, a, x, hit, r);
    endtask
    task automatic boot(input logic [15:1] base, input logic w, input logic [2:0] lvl);
        @(negedge clock_i);
        arst_n_i = 1'b0;
        strap_base_i = base;
        strap_wide_i = w;
        strap_irq_i = lvl;
        repeat (6) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check("status_lamp_o", 8'h01, {7'h0, status_lamp_o});
        for (n = 0; n < 520 && ready_o !== 1'b1; n++) @(negedge clock_i);
        check("ready_o", 8'h01, {7'h0, ready_o});
    endtask
    task automatic pulse(input int k);
        @(negedge clock_i);
        case (k)
            0: cfg_bad_addr_i = 1'b1;
            1, 2: mem_fail_i = 1'b1;
            3: parity_fail_i = 1'b1;
            4: irq_test_fail_i = 1'b1;
            5: fw_irq_req_i = 1'b1;
            6: init_done_i = 1'b1;
            8: selftest_done_i = 1'b1;
            default: nmi_taken_i = 1'b1;
        endcase
        @(negedge clock_i);
        {cfg_bad_addr_i, mem_fail_i, parity_fail_i, irq_test_fail_i} = 4'h0;
        {fw_irq_req_i, init_done_i, nmi_taken_i, selftest_done_i} = 4'h0;
        repeat (2) @(negedge clock_i);
    endtask
    task automatic mark(input int len);
        // Skip a mark already under way, it would be counted short
        for (n = 0; n < 40 && status_lamp_o === 1'b1; n++) @(negedge clock_i);
        for (n = 0; n < 40 && status_lamp_o !== 1'b1; n++) @(negedge clock_i);
        for (n = 0; n < 40 && status_lamp_o === 1'b1; n++) @(negedge clock_i);
        check("lamp_mark", 8'(len), 8'(n));
    endtask
    task automatic quiet(input int cyc);
        r = 8'h00;
        for (n = 0; n < cyc; n++) begin
            @(negedge clock_i);
            r[0] = r[0] | mst_abort_o;
        end
        check("mst_abort_o", 8'h00, r);
    endtask
    initial begin
        fw_status_i = 8'($random(seed));
        boot(15'h0000, 1'b1, 3'h0);
        mark(BL_CYC);
        rd(16'h0001, 8'h80);
        rd(16'h0000, fw_status_i);
        host.cycle(1'b0, 16'h0002, 8'h00, hit, r);
        host.cycle(1'b0, 16'h0100, 8'h00, hit, r);
        wr(16'h0000, 8'($random(seed)));
        pulse(5);
        check("irq_level", 8'h20, bus_interrupt_levels_o);
        rd(16'h0001, 8'hc0);
        rd(16'h0000, fw_status_i);
        pulse(5);
        wr(16'h0001, 8'h02);
        check("irq_level", 8'h00, bus_interrupt_levels_o);
        mst_req_i = 1'b1;
        for (n = 0; n < 260 && mst_abort_o !== 1'b1; n++) @(negedge clock_i);
        check("abort_time", 8'h01, {7'h0, n >= TMO_CYC - 1 && n <= TMO_CYC + 2});
        check("nmi_o", 8'h01, {7'h0, nmi_o});
        mst_req_i = 1'b0;
        pulse(7);
        repeat (20) @(negedge clock_i);
        check("halted_o", 8'h00, {7'h0, halted_o});
        mst_req_i = 1'b1;
        quiet(150);
        mst_ack_i = 1'b1;
        @(negedge clock_i);
        mst_ack_i = 1'b0;
        quiet(150);
        mst_req_i = 1'b0;
        pulse(6);
        repeat (12) @(negedge clock_i);
        check("status_lamp_o", 8'h00, {7'h0, status_lamp_o});
        b = 16'($random(seed));
        q = 3'($random(seed));
        // Timeout strap only counts when caught after a reset
        strap_timeout_en_i = 1'b0;
        boot(b[15:1], 1'b0, q);
        rd({~b[15:8], b[7:1], 1'b1}, 8'h80);
        pulse(5);
        check("irq_level", 8'h01 << (q ^ 3'h5), bus_interrupt_levels_o);
        mst_req_i = 1'b1;
        quiet(250);
        mst_req_i = 1'b0;
        strap_timeout_en_i = 1'b1;
        boot(15'h7fff, 1'b1, 3'h5);
        rd(16'hffff, 8'h80);
        host.cycle(1'b0, 16'h7fff, 8'h00, hit, r);
        for (int k = 0; k < 6; k++) begin
            boot(15'h0000, 1'b1, 3'h0);
            mem_fail_addr_i = (k == 1) ? 19'h1ffff : 19'h20000;
            if (k == 5) begin
                mst_req_i = 1'b1;
                for (n = 0; n < 260 && mst_abort_o !== 1'b1; n++) @(negedge clock_i);
                mst_req_i = 1'b0;
                repeat (20) @(negedge clock_i);
            end else pulse(k);
            check("halted_o", 8'h01, {7'h0, halted_o});
            rd(16'h0001, codes[k]);
            if (k == 0) for (int i = 7; i >= 0; i--) mark(codes[k][i] ? LG_CYC : SH_CYC);
        end
        wr(16'h0001, 8'h01);
        check("ready_o", 8'h00, {7'h0, ready_o});
        pulse(8);
        check("ready_o", 8'h01, {7'h0, ready_o});
        check("rd_q_left", 8'h00, 8'(rd_q.size()));
        wrap_up;
    end
    initial begin
        #500000;
        num_errors++;
        wrap_up;
    end
endmodule
